/* rtl/mvsp_dev.sv */
`timescale 1ns/1ps
// Contract
// - eight fixed rates, autodetected from host
// - ring and carrier high during reset
// - host uses RTS/CTS flow control
// - host drives DTR properly for idle
// - two-wire host paces data itself
// - flow control off ignores RTS, CTS
// - policy 0 sleeps on DTR level
module mvsp_dev
  import mvsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  mvsp_if.dev link,
  input wire logic flow_ctrl_en,
  input wire logic sleep_policy_command,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  input wire logic carrier_on,
  input wire logic ring_on,
  input wire logic set_ready,
  output logic sleep_ok,
  output logic rate_locked,
  output logic [2:0] rate_idx
);
  typedef enum logic [1:0] {
    MVSP_R_IDLE,
    MVSP_R_DATA,
    MVSP_R_STOP
  } mvsp_rst_t;

  typedef enum logic [1:0] {
    MVSP_T_IDLE,
    MVSP_T_SEND
  } mvsp_tst_t;

  typedef struct packed {
    logic locked;
    logic [2:0] rate;
    logic measuring;
    logic [15:0] meas;
    mvsp_rst_t rst;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic [7:0] buf0;
    logic [7:0] buf1;
    logic [1:0] fill;
    mvsp_tst_t tst;
    logic [15:0] tcnt;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic txd_line;
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
  } mvsp_dev_t;

  mvsp_dev_t s_q, s_d;
  logic [15:0] bit_cyc;
  logic push, pop;

  // nearest rate to a measured start bit width
  function automatic logic [2:0] mvsp_pick(input logic [15:0] w);
    logic [2:0] best;
    best = 3'h0;
    for (int i = 1; i < MVSP_NUM_RATES; i++) begin
      if (w < (mvsp_div(3'(i - 1)) + mvsp_div(3'(i))) / 2) begin
        best = 3'(i);
      end
    end
    mvsp_pick = best;
  endfunction

  assign bit_cyc = mvsp_div(s_q.rate);

  always_comb begin
    s_d = s_q;
    push = 1'b0;
    pop = rx_ready && (s_q.fill != 2'h0);
    // autobaud: time the first start bit, which must be an odd byte
    if (!s_q.locked) begin
      if (!s_q.measuring && !link.txd) begin
        s_d.measuring = 1'b1;
        s_d.meas = 16'h0001;
      end else if (s_q.measuring) begin
        if (link.txd) begin
          s_d.measuring = 1'b0;
          s_d.locked = 1'b1;
          s_d.rate = mvsp_pick(s_q.meas);
          s_d.rst = MVSP_R_DATA;
          s_d.rbit = 4'h1;
          s_d.rcnt = mvsp_div(mvsp_pick(s_q.meas)) >> 1;
        end else if (s_q.meas != MVSP_DIV_MAX) begin
          s_d.meas = s_q.meas + 16'h0001;
        end
      end
    end else begin
      case (s_q.rst)
        MVSP_R_IDLE: begin
          if (!link.txd) begin
            s_d.rst = MVSP_R_DATA;
            s_d.rbit = 4'h0;
            s_d.rcnt = bit_cyc >> 1;
          end
        end
        MVSP_R_DATA: begin
          if (s_q.rcnt == 16'h0000) begin
            s_d.rcnt = bit_cyc - 16'h0001;
            s_d.rbit = s_q.rbit + 4'h1;
            if (s_q.rbit == 4'h0 && link.txd) begin
              s_d.rst = MVSP_R_IDLE; // glitch, not a start bit
            end else if (s_q.rbit != 4'h0) begin
              s_d.rsh = {link.txd, s_q.rsh[7:1]};
            end
            if (s_q.rbit == 4'(MVSP_DATA_BITS)) begin
              s_d.rst = MVSP_R_STOP;
            end
          end else begin
            s_d.rcnt = s_q.rcnt - 16'h0001;
          end
        end
        MVSP_R_STOP: begin
          if (s_q.rcnt == 16'h0000) begin
            s_d.rst = MVSP_R_IDLE;
            // framing error drops the byte; full buffer overruns
            push = link.txd && (s_q.fill != MVSP_BUF_DEPTH || pop);
          end else begin
            s_d.rcnt = s_q.rcnt - 16'h0001;
          end
        end
        default: s_d.rst = MVSP_R_IDLE;
      endcase
    end
    // two-entry buffer toward the user
    if (pop) begin
      s_d.buf0 = s_q.buf1;
    end
    if (push) begin
      if (s_q.fill == 2'h0 || (s_q.fill == 2'h1 && pop)) begin
        s_d.buf0 = s_q.rsh;
      end else begin
        s_d.buf1 = s_q.rsh;
      end
    end
    s_d.fill = s_q.fill + {1'b0, push} - {1'b0, pop};
    // transmitter toward the host
    case (s_q.tst)
      MVSP_T_IDLE: begin
        s_d.txd_line = 1'b1;
        if (tx_ready && tx_valid) begin
          s_d.tst = MVSP_T_SEND;
          s_d.tsh = {1'b1, tx_data, 1'b0};
          s_d.tbit = 4'h0;
          s_d.tcnt = bit_cyc - 16'h0001;
          s_d.txd_line = 1'b0;
        end
      end
      MVSP_T_SEND: begin
        if (s_q.tcnt == 16'h0000) begin
          s_d.tcnt = bit_cyc - 16'h0001;
          s_d.tbit = s_q.tbit + 4'h1;
          s_d.txd_line = s_q.tsh[4'(s_q.tbit + 4'h1)];
          if (s_q.tbit == MVSP_LAST_BIT) begin
            s_d.tst = MVSP_T_IDLE;
            s_d.txd_line = 1'b1;
          end
        end else begin
          s_d.tcnt = s_q.tcnt - 16'h0001;
        end
      end
      default: s_d.tst = MVSP_T_IDLE;
    endcase
    s_d.dcd_n = !carrier_on;
    s_d.ri_n = !ring_on;
    s_d.dsr_n = !set_ready;
  end

  // no send before a rate is known; rts gates only with flow control
  assign tx_ready = s_q.locked && s_q.tst == MVSP_T_IDLE &&
    (!flow_ctrl_en || !link.rts_n);
  assign rx_valid = s_q.fill != 2'h0;
  assign rx_data = s_q.buf0;
  // one free slot kept so a byte in flight still lands
  assign link.cts_n = flow_ctrl_en ? (s_q.fill != 2'h0) : 1'b0;
  assign link.rxd = s_q.txd_line;
  assign link.dcd_n = s_q.dcd_n;
  assign link.ri_n = s_q.ri_n;
  assign link.dsr_n = s_q.dsr_n;
  assign sleep_ok = sleep_policy_command || link.dtr_n;
  assign rate_locked = s_q.locked;
  assign rate_idx = s_q.rate;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.rate <= MVSP_RATE_DEFAULT;
      s_q.rst <= MVSP_R_IDLE;
      s_q.tst <= MVSP_T_IDLE;
      s_q.txd_line <= 1'b1;
      s_q.dcd_n <= 1'b1;
      s_q.ri_n <= 1'b1;
      s_q.dsr_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* rtl/mvsp_host.sv */
`timescale 1ns/1ps
module mvsp_host
  import mvsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  mvsp_if.host link,
  input wire logic [2:0] rate_sel,
  input wire logic flow_ctrl_en,
  input wire logic terminal_ready,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic carrier,
  output logic ring,
  output logic set_ready
);
  typedef struct packed {
    logic tbusy;
    logic [15:0] tcnt;
    logic [3:0] tbit;
    logic [9:0] tsh;
    logic txd_line;
    logic rbusy;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rvalid;
    logic [7:0] rbyte;
  } mvsp_host_t;

  mvsp_host_t s_q, s_d;
  logic [15:0] bit_cyc;

  assign bit_cyc = mvsp_div(rate_sel);

  always_comb begin
    s_d = s_q;
    if (!s_q.tbusy) begin
      s_d.txd_line = 1'b1;
      if (tx_valid && tx_ready) begin
        s_d.tbusy = 1'b1;
        s_d.tsh = {1'b1, tx_data, 1'b0};
        s_d.tbit = 4'h0;
        s_d.tcnt = bit_cyc - 16'h0001;
        s_d.txd_line = 1'b0;
      end
    end else if (s_q.tcnt == 16'h0000) begin
      s_d.tcnt = bit_cyc - 16'h0001;
      s_d.tbit = s_q.tbit + 4'h1;
      s_d.txd_line = s_q.tsh[4'(s_q.tbit + 4'h1)];
      if (s_q.tbit == MVSP_LAST_BIT) begin
        s_d.tbusy = 1'b0;
        s_d.txd_line = 1'b1;
      end
    end else begin
      s_d.tcnt = s_q.tcnt - 16'h0001;
    end
    if (s_q.rvalid && rx_ready) begin
      s_d.rvalid = 1'b0;
    end
    if (!s_q.rbusy) begin
      if (!link.rxd) begin
        s_d.rbusy = 1'b1;
        s_d.rbit = 4'h0;
        s_d.rcnt = bit_cyc >> 1;
      end
    end else if (s_q.rcnt == 16'h0000) begin
      s_d.rcnt = bit_cyc - 16'h0001;
      s_d.rbit = s_q.rbit + 4'h1;
      if (s_q.rbit == 4'h0 && link.rxd) begin
        s_d.rbusy = 1'b0;
      end else if (s_q.rbit == MVSP_LAST_BIT) begin
        s_d.rbusy = 1'b0;
        if (link.rxd) begin
          s_d.rvalid = 1'b1;
          s_d.rbyte = s_q.rsh;
        end
      end else if (s_q.rbit != 4'h0) begin
        s_d.rsh = {link.rxd, s_q.rsh[7:1]};
      end
    end else begin
      s_d.rcnt = s_q.rcnt - 16'h0001;
    end
  end

  // without flow control the user paces traffic alone
  assign tx_ready = !s_q.tbusy &&
    (!flow_ctrl_en || !link.cts_n);
  // rts drops while a byte is unread; device may still finish one
  assign link.rts_n = flow_ctrl_en ? s_q.rvalid : 1'b0;
  assign link.txd = s_q.txd_line;
  assign link.dtr_n = !terminal_ready;
  assign rx_valid = s_q.rvalid;
  assign rx_data = s_q.rbyte;
  assign carrier = !link.dcd_n;
  assign ring = !link.ri_n;
  assign set_ready = !link.dsr_n;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.txd_line <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* rtl/mvsp_if.sv */
`timescale 1ns/1ps
interface mvsp_if;
  logic txd;         // host to modem serial data
  logic rxd;         // modem to host serial data
  logic rts_n;       // host ready to take data
  logic cts_n;       // modem ready to take data
  logic dtr_n;
  logic dsr_n;
  logic dcd_n;
  logic ri_n;
  modport dev (input txd, input rts_n, input dtr_n,
    output rxd, output cts_n, output dsr_n, output dcd_n, output ri_n);
  modport host (output txd, output rts_n, output dtr_n,
    input rxd, input cts_n, input dsr_n, input dcd_n, input ri_n);
endinterface

/* rtl/mvsp_pkg.sv */
package mvsp_pkg;
  localparam int unsigned MVSP_CLK_HZ = 20000000;
  localparam int unsigned MVSP_NUM_RATES = 8;
  localparam logic [2:0] MVSP_RATE_DEFAULT = 3'h7;
  // baud figures, index 0 = 1200 .. 7 = 115200
  localparam int unsigned MVSP_BAUD [MVSP_NUM_RATES] = '{
    1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  localparam int unsigned MVSP_DATA_BITS = 8;
  localparam logic [15:0] MVSP_DIV_MAX = 16'hFFFF;
  localparam logic [3:0] MVSP_LAST_BIT = 4'h9;
  localparam logic [1:0] MVSP_BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    MVSP_FC_NONE,
    MVSP_FC_HW
  } mvsp_fc_t;

  // cycles per bit at one rate
  function automatic logic [15:0] mvsp_div(input logic [2:0] idx);
    mvsp_div = 16'(MVSP_CLK_HZ / MVSP_BAUD[idx]);
  endfunction
endpackage

/* tb/modem_v24_serial_port_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module modem_v24_serial_port_bench;
  logic sys_clk = 0, reset = 1, fc = 1, pol = 0, trdy = 0, car = 1, rng = 1;
  logic d_tv = 0, h_tv = 0, d_rr = 0, h_rr = 0, d_trdy, h_trdy, d_rv, h_rv;
  logic slp, lock, h_car, h_rng, h_sr, hfc = 1, srdy = 0;
  logic [7:0] d_td = 8'h00, h_td = 8'h00, d_rd, h_rd;
  logic [2:0] rsel = 3'h7, ridx;
  int n_errors = 0, n_compared = 0;
  always #25 sys_clk = ~sys_clk;
  mvsp_if link();
  mvsp_dev i_mvsp_dev (.sys_clk(sys_clk), .reset(reset), .link(link.dev),
    .flow_ctrl_en(fc), .sleep_policy_command(pol), .tx_valid(d_tv),
    .tx_ready(d_trdy), .tx_data(d_td), .rx_valid(d_rv), .rx_ready(d_rr),
    .rx_data(d_rd), .carrier_on(car), .ring_on(rng), .set_ready(srdy),
    .sleep_ok(slp), .rate_locked(lock), .rate_idx(ridx));
  mvsp_host i_mvsp_host (.sys_clk(sys_clk), .reset(reset), .link(link.host),
    .rate_sel(rsel), .flow_ctrl_en(hfc), .terminal_ready(trdy),
    .tx_valid(h_tv), .tx_ready(h_trdy), .tx_data(h_td), .rx_valid(h_rv),
    .rx_ready(h_rr), .rx_data(h_rd), .carrier(h_car), .ring(h_rng),
    .set_ready(h_sr));
  mvsp_assertions i_mvsp_assertions (.sys_clk(sys_clk), .reset(reset),
    .flow_ctrl_en(fc), .txd(link.txd), .rxd(link.rxd), .rts_n(link.rts_n),
    .cts_n(link.cts_n), .dsr_n(link.dsr_n), .dcd_n(link.dcd_n),
    .ri_n(link.ri_n));
  ////////////////////////////////////////
  task automatic complete_run;
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // dev selects the modem end, else the host end
  task automatic send(input bit dev, input logic [7:0] b);
    int k;
    @(negedge sys_clk);
    if (dev) {d_td, d_tv} = {b, 1'b1};
    else {h_td, h_tv} = {b, 1'b1};
    // ready stands between edges; the next rising edge takes the byte
    while ((dev ? d_trdy : h_trdy) !== 1'b1 && k < 40000) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK("taken", 1'b1, dev ? d_trdy : h_trdy)
    @(negedge sys_clk);
    {d_tv, h_tv} = 2'h0;
  endtask
  task automatic recv(input bit dev, input logic [7:0] e);
    int k;
    do begin
      @(negedge sys_clk);
      k++;
    end while ((dev ? d_rv : h_rv) !== 1'b1 && k < 40000);
    `CHK("rx_valid", 1'b1, dev ? d_rv : h_rv)
    `CHK("rx_data", e, dev ? d_rd : h_rd)
    {d_rr, h_rr} = {dev, !dev};
    @(negedge sys_clk);
    {d_rr, h_rr} = 2'h0;
  endtask
  ////////////////////////////////////////
  initial begin
    // slow rates skipped: one 1200 baud byte alone costs 166k cycles
    for (int r = 4; r < 8; r++) begin
      @(negedge sys_clk);
      reset = 1;
      rsel = 3'(r);
      repeat (8) @(negedge sys_clk);
      `CHK("dcd_ri", 2'h3, {link.dcd_n, link.ri_n})
      reset = 0;
      send(0, 8'hA5);
      recv(1, 8'hA5);
      `CHK("rate", {1'b1, 3'(r)}, {lock, ridx})
      send(1, 8'h3C);
      recv(0, 8'h3C);
    end
    send(1, 8'h11);
    repeat (2000) @(negedge sys_clk);
    `CHK("dev_tx_ready", 1'b0, d_trdy)
    recv(0, 8'h11);
    send(1, 8'h22);
    recv(0, 8'h22);
    send(0, 8'h33);
    repeat (2000) @(negedge sys_clk);
    `CHK("host_tx_ready", 1'b0, h_trdy)
    recv(1, 8'h33);
    fc = 0;
    hfc = 0;
    send(0, 8'h44);
    send(0, 8'h55);
    recv(1, 8'h44);
    recv(1, 8'h55);
    // host turns flow control back on and leaves 8'h77 unread, so rts_n rises; the device, its flow control still off, keeps sending
    hfc = 1;
    send(1, 8'h77);
    repeat (2000) @(negedge sys_clk);
    `CHK("rts_n", 1'b1, link.rts_n)
    send(1, 8'h88);
    repeat (2000) @(negedge sys_clk);
    recv(0, 8'h88);
    for (int i = 0; i < 4; i++) begin
      pol = i[1];
      trdy = i[0];
      srdy = ~i[0];
      car = i[0];
      rng = i[1];
      repeat (4) @(negedge sys_clk);
      `CHK("sleep_ok", i[1] | ~i[0], slp)
      `CHK("dcd_ri_host", {i[0], i[1]}, {h_car, h_rng})
      `CHK("set_ready", ~i[0], h_sr)
    end
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end
endmodule

/* tb/mvsp_assertions.sv */
`timescale 1ns/1ps
module mvsp_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic flow_ctrl_en,
  input wire logic txd,
  input wire logic rxd,
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n
);
  default clocking cb @(posedge sys_clk); endclocking
  ////////////////////////////////////////
  // watched during reset too, so no disable
  idle_hold_a: assert property (
    reset |=> ri_n && dcd_n && dsr_n && rxd)
    else $error("lines not idle in reset");
  // a low bit lasts 173 cycles even at the top rate
  low_bit_a: assert property (
    disable iff (reset) $fell(rxd) |=> (!rxd) [*8])
    else $error("low bit too short");
  rts_gate_a: assert property (
    disable iff (reset) (flow_ctrl_en && rts_n) [*8] |-> !$fell(rxd))
    else $error("sent while host stalled");
  cts_gate_a: assert property (
    disable iff (reset) (flow_ctrl_en && cts_n) [*8] |-> !$fell(txd))
    else $error("sent while modem stalled");
  cts_rise_a: assert property (
    disable iff (reset) flow_ctrl_en && $rose(cts_n) |-> txd)
    else $error("stall raised mid bit");
  cts_off_a: assert property (
    disable iff (reset) (!flow_ctrl_en) [*3] |-> !cts_n)
    else $error("stall with flow off");
endmodule
